// ==== rtl/pkpc_map.svh ====
/*
 Register offsets, field masks and bus codes of the port K pin configuration block.
 Assumes inclusion by bare name from the rtl folder.
*/
`ifndef PKPC_MAP_SVH
`define PKPC_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define PKPC_AW          8
`define PKPC_OFS_FSEL2   8'h0C
`define PKPC_OFS_PUP     8'h2C
`define PKPC_OFS_IE      8'h38

// ****************************************
// Implemented bits and reset values
// ****************************************
`define PKPC_FSEL2_MASK  32'h0000_0002
`define PKPC_PUP_MASK    32'h0000_0006
`define PKPC_IE_MASK     32'h0000_0007
`define PKPC_RST_VAL     32'h0000_0000
`define PKPC_ALARM_BIT   1

// ****************************************
// Response codes
// ****************************************
`define PKPC_RESP_OKAY   2'h0
`define PKPC_RESP_SLVERR 2'h2

`endif

// ==== rtl/pkpc_pkg.sv ====
/*
 Types shared by the port K pin configuration files.
 Assumes nothing of its surroundings.
*/
package pkpc_pkg;
   typedef logic [31:0] pkpc_word_t;   // Bus data word
   typedef logic [7:0]  pkpc_addr_t;   // Byte address
   typedef logic [2:0]  pkpc_pins_t;   // One bit per pin
   typedef logic [1:0]  pkpc_resp_t;   // Bus response code
endpackage : pkpc_pkg

// ==== rtl/pkpc_reg_if.sv ====
/*
 Register access carrier between bus slave and register file.
 Assumes one clock; strobes are single-cycle.
*/
`timescale 1ns/1ps
`default_nettype none
interface pkpc_reg_if;
   import pkpc_pkg::*;
   logic       wr_stb;   // Write one word now
   pkpc_addr_t wr_addr;  // Write address
   pkpc_word_t wr_data;  // Write data
   logic [3:0] wr_strb;  // Write byte lanes
   logic       wr_err;   // Write address unmapped
   logic       rd_stb;   // Read one word now
   pkpc_addr_t rd_addr;  // Read address
   pkpc_word_t rd_data;  // Read data, same cycle
   logic       rd_err;   // Read address unmapped
   modport bus  (output wr_stb, wr_addr, wr_data, wr_strb, rd_stb, rd_addr,
                 input wr_err, rd_data, rd_err);
   modport regs (input wr_stb, wr_addr, wr_data, wr_strb, rd_stb, rd_addr,
                 output wr_err, rd_data, rd_err);
endinterface : pkpc_reg_if
`default_nettype wire

// ==== rtl/pkpc_axil_slave.sv ====
/*
 AXI4-Lite slave front end: takes address and data in any order, one write
 and one read at a time, and passes single-cycle strobes to the registers.
 Assumes the register side answers combinationally in the strobe cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pkpc_map.svh"
module pkpc_axil_slave (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire pkpc_pkg::pkpc_addr_t awaddr,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire pkpc_pkg::pkpc_word_t wdata,
   input  wire logic [3:0]          wstrb,
   input  wire logic                wvalid,
   output logic                     wready,
   output pkpc_pkg::pkpc_resp_t     bresp,
   output logic                     bvalid,
   input  wire logic                bready,
   input  wire pkpc_pkg::pkpc_addr_t araddr,
   input  wire logic                arvalid,
   output logic                     arready,
   output pkpc_pkg::pkpc_word_t     rdata,
   output pkpc_pkg::pkpc_resp_t     rresp,
   output logic                     rvalid,
   input  wire logic                rready,
   pkpc_reg_if.bus                  rif
);
   import pkpc_pkg::*;

   // ****************************************
   // Holding registers
   // ****************************************
   logic       aw_full_r;  // Write address held
   logic       w_full_r;   // Write data held
   pkpc_addr_t awaddr_r;   // Held address
   pkpc_word_t wdata_r;    // Held data
   logic [3:0] wstrb_r;    // Held lanes
   logic       bvalid_r;   // Write answer pending
   pkpc_resp_t bresp_r;    // Write answer code
   logic       rvalid_r;   // Read answer pending
   pkpc_resp_t rresp_r;    // Read answer code
   pkpc_word_t rdata_r;    // Read answer data

   // Handshake terms
   wire aw_take = awvalid & awready;
   wire w_take  = wvalid & wready;
   wire do_wr   = aw_full_r & w_full_r & ~bvalid_r;
   wire do_rd   = arvalid & arready;

   assign awready = ~aw_full_r;
   assign wready  = ~w_full_r;
   assign arready = ~rvalid_r;
   assign bvalid  = bvalid_r;
   assign bresp   = bresp_r;
   assign rvalid  = rvalid_r;
   assign rresp   = rresp_r;
   assign rdata   = rdata_r;

   // Strobes toward the register file
   assign rif.wr_stb  = do_wr;
   assign rif.wr_addr = awaddr_r;
   assign rif.wr_data = wdata_r;
   assign rif.wr_strb = wstrb_r;
   assign rif.rd_stb  = do_rd;
   assign rif.rd_addr = araddr;

   // Write address and data capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
      end else begin
         aw_full_r <= do_wr ? 1'b0 : (aw_full_r | aw_take);
         w_full_r  <= do_wr ? 1'b0 : (w_full_r | w_take);
      end
      if (aw_take) awaddr_r <= awaddr;
      if (w_take) begin
         wdata_r <= wdata;
         wstrb_r <= wstrb;
      end
   end

   // Write answer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r  <= `PKPC_RESP_OKAY;
      end else if (do_wr) begin
         bvalid_r <= 1'b1;
         bresp_r  <= rif.wr_err ? `PKPC_RESP_SLVERR : `PKPC_RESP_OKAY;
      end else if (bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // Read answer, data registered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rresp_r  <= `PKPC_RESP_OKAY;
         rdata_r  <= `PKPC_RST_VAL;
      end else if (do_rd) begin
         rvalid_r <= 1'b1;
         rresp_r  <= rif.rd_err ? `PKPC_RESP_SLVERR : `PKPC_RESP_OKAY;
         rdata_r  <= rif.rd_data;
      end else if (rready) begin
         rvalid_r <= 1'b0;
      end
   end
endmodule : pkpc_axil_slave
`default_nettype wire

// ==== rtl/pkpc_port_k.sv ====
/*
 Port K pin configuration: second function select, pull-up enables for pins 2-1, input
 enables for three pins, reset forcing and the pin multiplexers.
 Assumes data, output-enable and first function bits come from elsewhere.
*/
// Summary of operation
// (R01) Bit 1 selects alarm output on pin 1
// (R02) Bits 2-1 enable pin pull-ups
// (R03) Bits 2-0 enable pin input buffers
// (R04) Reset-forced pull-ups are off during reset
// (R05) Reset-independent features follow their register in reset
// (R06) Boot-strap pin input stays enabled in reset
// (R07) Peripheral enable decides drive in function mode
// (R08) Registers at 0x0C, 0x2C and 0x38
// (R09) Unused bits ignore writes, read zero
`timescale 1ns/1ps
`default_nettype none
`include "pkpc_map.svh"
module pkpc_port_k #(
   parameter pkpc_pkg::pkpc_pins_t PUP_NOR_MASK  = 3'h0, // Pull-ups kept in reset
   parameter pkpc_pkg::pkpc_pins_t BOOT_PIN_MASK = 3'h0  // Boot-strap pins
) (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // Register bus
   input  wire pkpc_pkg::pkpc_addr_t awaddr,
   input  wire logic                 awvalid,
   output logic                      awready,
   input  wire pkpc_pkg::pkpc_word_t wdata,
   input  wire logic [3:0]           wstrb,
   input  wire logic                 wvalid,
   output logic                      wready,
   output pkpc_pkg::pkpc_resp_t      bresp,
   output logic                      bvalid,
   input  wire logic                 bready,
   input  wire pkpc_pkg::pkpc_addr_t araddr,
   input  wire logic                 arvalid,
   output logic                      arready,
   output pkpc_pkg::pkpc_word_t      rdata,
   output pkpc_pkg::pkpc_resp_t      rresp,
   output logic                      rvalid,
   input  wire logic                 rready,
   // Port settings kept elsewhere
   input  wire pkpc_pkg::pkpc_pins_t port_data,
   input  wire pkpc_pkg::pkpc_pins_t port_oe,
   input  wire pkpc_pkg::pkpc_pins_t fsel1,
   // Peripheral side
   input  wire logic                 timer_out,
   input  wire logic                 clk_out,
   input  wire logic                 alarm_output,
   input  wire logic                 cec_out,
   input  wire logic                 cec_out_en,
   output logic                      cec_in,
   output pkpc_pkg::pkpc_pins_t      pin_in,
   output logic                      pin1_alarm_select,
   // Pads
   input  wire pkpc_pkg::pkpc_pins_t pad_in,
   output pkpc_pkg::pkpc_pins_t      pad_out,
   output pkpc_pkg::pkpc_pins_t      pad_drive_n,
   output pkpc_pkg::pkpc_pins_t      pad_pullup,
   output pkpc_pkg::pkpc_pins_t      pad_input_en
);
   import pkpc_pkg::*;

   // ****************************************
   // Address decode
   // ****************************************

   // One-hot select: bit 0 function two, 1 pull-up, 2 input
   function automatic pkpc_pins_t reg_sel(input pkpc_addr_t a);
      pkpc_pins_t s;
      s    = 3'h0;
      s[0] = ({a[7:2], 2'h0} == `PKPC_OFS_FSEL2);
      s[1] = ({a[7:2], 2'h0} == `PKPC_OFS_PUP);
      s[2] = ({a[7:2], 2'h0} == `PKPC_OFS_IE);
      return s;
   endfunction : reg_sel

   pkpc_reg_if rif ();          // Slave to register carrier

   // Bus front end
   pkpc_axil_slave u_slave (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .rif     (rif)
   );

   // ****************************************
   // Register file
   // ****************************************
   pkpc_word_t fsel2_r, fsel2_nxt;  // Second function select
   pkpc_word_t pup_r,   pup_nxt;    // Pull-up enables
   pkpc_word_t ie_r,    ie_nxt;     // Input enables

   wire pkpc_pins_t wsel   = reg_sel(rif.wr_addr);  // Write target
   wire pkpc_pins_t rsel   = reg_sel(rif.rd_addr);  // Read target
   wire             lane0  = rif.wr_stb & rif.wr_strb[0]; // Low byte written

   // Masked next values; unused bits never stored
   assign fsel2_nxt = (lane0 & wsel[0]) ? (rif.wr_data & `PKPC_FSEL2_MASK) : fsel2_r; // R01 R09
   assign pup_nxt   = (lane0 & wsel[1]) ? (rif.wr_data & `PKPC_PUP_MASK) : pup_r;     // R02 R09
   assign ie_nxt    = (lane0 & wsel[2]) ? (rif.wr_data & `PKPC_IE_MASK) : ie_r;       // R03 R09

   // Unmapped addresses answered with an error
   assign rif.wr_err = (wsel == 3'h0);  // R08
   assign rif.rd_err = (rsel == 3'h0);  // R08

   // Read multiplexer
   assign rif.rd_data = ({32{rsel[0]}} & fsel2_r) |
                        ({32{rsel[1]}} & pup_r) |
                        ({32{rsel[2]}} & ie_r);  // R08

   // Register update, all cleared by reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fsel2_r <= `PKPC_RST_VAL;  // R01
         pup_r   <= `PKPC_RST_VAL;  // R02
         ie_r    <= `PKPC_RST_VAL;  // R03
      end else begin
         fsel2_r <= fsel2_nxt;
         pup_r   <= pup_nxt;
         ie_r    <= ie_nxt;
      end
   end

   // ****************************************
   // Pin control
   // ****************************************
   wire        in_reset  = ~aresetn;                       // Reset level
   wire        alarm_sel = fsel2_r[`PKPC_ALARM_BIT];       // Pin 1 to alarm
   wire pkpc_pins_t pup_en = pup_r[2:0];                   // Pull-up bits
   wire pkpc_pins_t ie_en  = ie_r[2:0];                    // Input bits

   assign pin1_alarm_select = alarm_sel;

   // Pull-ups: forced off in reset unless marked independent
   assign pad_pullup = pup_en & (PUP_NOR_MASK | {3{aresetn}});  // R04 R05

   // Input buffers: boot pins forced on in reset
   assign pad_input_en = ie_en | (BOOT_PIN_MASK & {3{in_reset}});  // R03 R06

   // Gated input data
   assign pin_in = pad_in & pad_input_en;  // R03
   assign cec_in = pin_in[0];

   // Pin 2: timer output or port data
   assign pad_out[2]     = fsel1[2] ? timer_out : port_data[2];
   assign pad_drive_n[2] = ~port_oe[2];

   // Pin 1: alarm wins over clock output, then port data
   assign pad_out[1]     = alarm_sel ? alarm_output :
                           (fsel1[1] ? clk_out : port_data[1]);  // R01
   assign pad_drive_n[1] = ~port_oe[1];

   // Pin 0: open drain, only ever pulls low
   wire cec_pull  = cec_out_en & ~cec_out;   // Peripheral pulls line
   wire port_pull = port_oe[0] & ~port_data[0];
   assign pad_out[0]     = 1'b0;
   assign pad_drive_n[0] = fsel1[0] ? ~cec_pull : ~port_pull;  // R07

   // ****************************************
   // Assertions
   // ****************************************

   // Reset seen at the previous edge; keeps the independent pull-up check off the first edge,
   // where the registers have not yet been cleared
   logic rst_seen_r;  // Delayed reset level
   always_ff @(posedge aclk) begin
      rst_seen_r <= in_reset;
   end

   // Unused bits of the function select and pull-up registers stay zero
   a_fsel_unused: assert property (@(posedge aclk) disable iff (!aresetn) // R09
      (fsel2_r & ~`PKPC_FSEL2_MASK) == `PKPC_RST_VAL)
      else $error("function select unused bit set");

   a_pup_unused: assert property (@(posedge aclk) disable iff (!aresetn) // R09
      (pup_r & ~`PKPC_PUP_MASK) == `PKPC_RST_VAL)
      else $error("pull-up unused bit set");

   // Pull-up write lands one cycle later
   a_pup_write: assert property (@(posedge aclk) disable iff (!aresetn) // R02
      (lane0 && wsel[1]) |=> pup_r == ($past(rif.wr_data) & `PKPC_PUP_MASK))
      else $error("pull-up write not stored");

   // Input enable readback matches register
   a_ie_read: assert property (@(posedge aclk) disable iff (!aresetn) // R08
      (rif.rd_stb && rsel[2]) |=> rdata == $past(ie_r) && rvalid)
      else $error("input enable readback wrong");

   // Disabled pin 1 input reads zero
   a_ie_gate: assert property (@(posedge aclk) disable iff (!aresetn) // R03
      !ie_r[1] |-> !pin_in[1])
      else $error("disabled input passes data");

   // Forced pull-ups off while in reset
   a_pup_forced: assert property (@(posedge aclk) // R04
      !aresetn |-> (pad_pullup & ~PUP_NOR_MASK) == 3'h0)
      else $error("pull-up active in reset");

   // Independent pull-ups follow register in reset
   a_pup_indep: assert property (@(posedge aclk) // R05
      (!aresetn && rst_seen_r) |-> (pad_pullup & PUP_NOR_MASK) == (pup_en & PUP_NOR_MASK))
      else $error("independent pull-up changed by reset");

   // Boot pin input on during reset
   a_boot_in: assert property (@(posedge aclk) // R06
      !aresetn |-> (pad_input_en & BOOT_PIN_MASK) == BOOT_PIN_MASK)
      else $error("boot input disabled in reset");

   // Alarm routed to pin 1 after select write
   a_alarm_route: assert property (@(posedge aclk) disable iff (!aresetn) // R01
      (lane0 && wsel[0] && rif.wr_data[`PKPC_ALARM_BIT]) |=> pad_out[1] == alarm_output)
      else $error("alarm not routed to pin 1");

   // Peripheral enable owns pin 0 in function mode
   a_cec_drive: assert property (@(posedge aclk) disable iff (!aresetn) // R07
      fsel1[0] |-> pad_drive_n[0] == !(cec_out_en && !cec_out))
      else $error("pin 0 drive not from peripheral");

   // Unmapped write answered with error
   a_unmapped_wr: assert property (@(posedge aclk) disable iff (!aresetn) // R08
      (rif.wr_stb && wsel == 3'h0) |=> bvalid && bresp == `PKPC_RESP_SLVERR)
      else $error("unmapped write not refused");

   // Input enable unused bits stay zero
   a_ie_unused: assert property (@(posedge aclk) disable iff (!aresetn) // R09
      (ie_r & ~`PKPC_IE_MASK) == `PKPC_RST_VAL)
      else $error("input enable unused bit set");

   // Function select write lands one cycle later
   a_fsel_write: assert property (@(posedge aclk) disable iff (!aresetn) // R01
      (lane0 && wsel[0]) |=> fsel2_r == ($past(rif.wr_data) & `PKPC_FSEL2_MASK))
      else $error("function select write not stored");

   // Input enable write lands one cycle later
   a_ie_write: assert property (@(posedge aclk) disable iff (!aresetn) // R03
      (lane0 && wsel[2]) |=> ie_r == ($past(rif.wr_data) & `PKPC_IE_MASK))
      else $error("input enable write not stored");

   // Write without the low lane changes nothing
   a_lane_skip: assert property (@(posedge aclk) disable iff (!aresetn) // R09
      (rif.wr_stb && !rif.wr_strb[0]) |=> $stable(fsel2_r) && $stable(pup_r) && $stable(ie_r))
      else $error("write without low lane changed a register");

   // Unmapped read answered with error and zero
   a_unmapped_rd: assert property (@(posedge aclk) disable iff (!aresetn) // R08
      (rif.rd_stb && rsel == 3'h0) |=> rvalid && rresp == `PKPC_RESP_SLVERR && rdata == `PKPC_RST_VAL)
      else $error("unmapped read not refused");

   // Function select readback matches register
   a_fsel_read: assert property (@(posedge aclk) disable iff (!aresetn) // R08
      (rif.rd_stb && rsel[0]) |=> rdata == $past(fsel2_r) && rvalid)
      else $error("function select readback wrong");

   // Pull-up readback matches register
   a_pup_read: assert property (@(posedge aclk) disable iff (!aresetn) // R08
      (rif.rd_stb && rsel[1]) |=> rdata == $past(pup_r) && rvalid)
      else $error("pull-up readback wrong");

   // Alarm owns pin 1 whenever selected
   a_alarm_prio: assert property (@(posedge aclk) disable iff (!aresetn) // R01
      alarm_sel |-> pad_out[1] == alarm_output)
      else $error("alarm does not own pin 1");

   // Out of reset pull-ups follow their bits
   a_pup_follow: assert property (@(posedge aclk) disable iff (!aresetn) // R02
      pad_pullup == pup_en)
      else $error("pull-up differs from register");

   // Out of reset input buffers follow their bits
   a_ie_follow: assert property (@(posedge aclk) disable iff (!aresetn) // R03
      pad_input_en == ie_en)
      else $error("input enable differs from register");

   // Main scenarios
   c_mid_reset: cover property (@(posedge aclk)
      aresetn ##1 !aresetn);
   c_alarm_on: cover property (@(posedge aclk) disable iff (!aresetn)
      alarm_sel && fsel1[1]);
   c_pup_write: cover property (@(posedge aclk) disable iff (!aresetn)
      lane0 && wsel[1] ##1 pad_pullup != 3'h0);
   c_read_ie: cover property (@(posedge aclk) disable iff (!aresetn)
      rif.rd_stb && rsel[2] ##1 rvalid);
   c_cec_pull: cover property (@(posedge aclk) disable iff (!aresetn)
      fsel1[0] && !pad_drive_n[0]);
endmodule : pkpc_port_k
`default_nettype wire

// ==== verification/port_k_pin_config_bench.sv ====
/*
 Self-checking bench for the port K pin configuration block.
 Assumes the rtl package and map header are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pkpc_map.svh"
module port_k_pin_config_bench;
   import pkpc_pkg::*;
   // ****************************************
   // Stimulus signals
   // ****************************************
   logic       aclk, aresetn;            // Clock, reset
   pkpc_addr_t awaddr, araddr;           // Addresses
   pkpc_word_t wdata, rdata;             // Data
   logic [3:0] wstrb;                    // Lanes
   logic       awvalid, awready, wvalid, wready, bvalid, bready;
   logic       arvalid, arready, rvalid, rready;
   pkpc_resp_t bresp, rresp;             // Responses
   pkpc_pins_t port_data, port_oe, fsel1, pad_in;
   pkpc_pins_t pin_in, pad_out, pad_drive_n, pad_pullup, pad_input_en;
   logic       timer_out, clk_out, alarm_output, cec_out, cec_out_en;
   logic       cec_in, pin1_alarm_select;
   int         failures, tests_run;      // Counters

   // Pin 2 pull-up survives reset, pin 1 is the boot-strap input
   pkpc_port_k #(.PUP_NOR_MASK(3'h4), .BOOT_PIN_MASK(3'h2)) DUT (.*);

   // ****************************************
   // Clock
   // ****************************************
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // ****************************************
   // Compare and report
   // ****************************************
   task automatic final_report;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report

   task automatic check_word(input string n, input pkpc_word_t e, input pkpc_word_t g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : check_word

   task automatic check_resp(input string n, input pkpc_resp_t e, input pkpc_resp_t g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : check_resp

   task automatic check_pins(input string n, input pkpc_pins_t e, input pkpc_pins_t g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : check_pins

   // Bound on every wait
   task automatic limit(input int n);
      if (n >= 50) begin
         failures++;
         $display("wrong value wait expected answer seen none");
         final_report();
      end
   endtask : limit

   // ****************************************
   // Bus cycles
   // ****************************************
   task automatic axi_write(input pkpc_addr_t a, input pkpc_word_t d, input pkpc_resp_t er);
      int   n;
      logic aw_on, w_on;
      n = 0;
      aw_on = 1'b1;
      w_on  = 1'b1;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      // Address and data released each on its own ready; local flags track
      // what is still offered, as valid itself only changes after the edge
      while ((aw_on || w_on) && n < 50) begin
         @(posedge aclk);
         n++;
         if (aw_on && awready) begin
            awvalid <= 1'b0;
            aw_on = 1'b0;
         end
         if (w_on && wready) begin
            wvalid <= 1'b0;
            w_on = 1'b0;
         end
      end
      while (!bvalid && n < 50) begin
         @(posedge aclk);
         n++;
      end
      limit(n);
      check_resp("bresp", er, bresp);
      bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input pkpc_addr_t a, input pkpc_word_t ed, input pkpc_resp_t er);
      int n;
      n = 0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!(arvalid && arready) && n < 50) begin
         @(posedge aclk);
         n++;
      end
      arvalid <= 1'b0;
      while (!rvalid && n < 50) begin
         @(posedge aclk);
         n++;
      end
      limit(n);
      check_word("rdata", ed, rdata);
      check_resp("rresp", er, rresp);
      rready <= 1'b0;
   endtask : axi_read

   // ****************************************
   // Scenarios
   // ****************************************
   // Reset values and placement
   task automatic test_reset_values;
      axi_read(8'h0C, 32'h0, 2'h0);
      axi_read(8'h2C, 32'h0, 2'h0);
      axi_read(8'h38, 32'h0, 2'h0);
   endtask : test_reset_values

   // All-ones writes keep only the implemented bits
   task automatic test_masking;
      axi_write(8'h0C, 32'hFFFF_FFFF, 2'h0);
      axi_write(8'h2C, 32'hFFFF_FFFF, 2'h0);
      axi_write(8'h38, 32'hFFFF_FFFF, 2'h0);
      axi_read(8'h0C, 32'h0000_0002, 2'h0);
      axi_read(8'h2C, 32'h0000_0006, 2'h0);
      axi_read(8'h38, 32'h0000_0007, 2'h0);
      // Unmapped place refused
      axi_write(8'h10, 32'hFFFF_FFFF, 2'h2);
      axi_read(8'h10, 32'h0, 2'h2);
   endtask : test_masking

   // Register bits reach the pins
   task automatic test_pins;
      @(posedge aclk);
      pad_in       <= 3'h5;
      alarm_output <= 1'b1;
      #1;
      check_pins("pullup", 3'h6, pad_pullup);
      check_pins("input_en", 3'h7, pad_input_en);
      check_pins("pin_in", 3'h5, pin_in);
      check_pins("cec_in", 3'h1, {2'h0, cec_in});
      check_pins("alarm_sel", 3'h1, {2'h0, pin1_alarm_select});
      check_pins("alarm_pin", 3'h1, {2'h0, pad_out[1]});
      axi_write(8'h0C, 32'h0, 2'h0);
      axi_write(8'h38, 32'h2, 2'h0);
      #1;
      check_pins("alarm_sel", 3'h0, {2'h0, pin1_alarm_select});
      check_pins("pin_in", 3'h0, pin_in);
   endtask : test_pins

   // Peripheral enable decides drive of pin 0
   task automatic test_func_enable;
      @(posedge aclk);
      fsel1      <= 3'h1;
      port_oe    <= 3'h1;
      port_data  <= 3'h0;
      cec_out    <= 1'b0;
      cec_out_en <= 1'b0;
      #1;
      check_pins("drive_n", 3'h1, {2'h0, pad_drive_n[0]});
      @(posedge aclk);
      cec_out_en <= 1'b1;
      port_oe    <= 3'h0;
      #1;
      check_pins("drive_n", 3'h0, {2'h0, pad_drive_n[0]});
      @(posedge aclk);
      fsel1 <= 3'h0;
      #1;
      check_pins("drive_n", 3'h1, {2'h0, pad_drive_n[0]});
   endtask : test_func_enable

   // Pin 1 and pin 2 multiplexers, alarm over clock output
   task automatic test_pin_mux;
      axi_write(8'h0C, 32'h2, 2'h0);
      @(posedge aclk);
      fsel1        <= 3'h6;
      port_oe      <= 3'h6;
      port_data    <= 3'h0;
      timer_out    <= 1'b1;
      clk_out      <= 1'b0;
      alarm_output <= 1'b1;
      #1;
      check_pins("pad_out", 3'h6, pad_out);
      check_pins("drive_n_all", 3'h1, pad_drive_n);
      @(posedge aclk);
      alarm_output <= 1'b0;
      clk_out      <= 1'b1;
      #1;
      check_pins("pad_out", 3'h4, pad_out);
      axi_write(8'h0C, 32'h0, 2'h0);
      #1;
      check_pins("pad_out", 3'h6, pad_out);
      @(posedge aclk);
      fsel1     <= 3'h0;
      port_data <= 3'h2;
      #1;
      check_pins("pad_out", 3'h2, pad_out);
   endtask : test_pin_mux

   // Forced, kept and boot-strap behaviour in reset
   task automatic test_reset_force;
      axi_write(8'h2C, 32'h6, 2'h0);
      axi_write(8'h38, 32'h1, 2'h0);
      @(posedge aclk);
      aresetn <= 1'b0;
      #1;
      check_pins("pullup_rst", 3'h4, pad_pullup);
      check_pins("input_rst", 3'h3, pad_input_en);
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      #1;
      check_pins("input_rel", 3'h0, pad_input_en);
      axi_read(8'h2C, 32'h0, 2'h0);
   endtask : test_reset_force

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      failures = 0;
      tests_run = 0;
      aresetn = 1'b0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {port_data, port_oe, fsel1, pad_in} = '0;
      {timer_out, clk_out, alarm_output, cec_out, cec_out_en} = '0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      test_reset_values();
      test_masking();
      test_pins();
      test_func_enable();
      test_pin_mux();
      test_reset_force();
      final_report();
   end
endmodule : port_k_pin_config_bench
`default_nettype wire
